// ===== src/gpm_params.svh
/*
 Constants for the pin function mux: register offsets, field positions and
 reset values. Assumes inclusion by gpm_pin_mux only.
*/
`ifndef GPM_PARAMS_SVH
`define GPM_PARAMS_SVH
// Register indices; byte address is four times the index
`define GPM_IDX_PIN2_CFG 8'h0C
`define GPM_IDX_IO_PORT 8'h0E
`define GPM_ADDR_PIN2_CFG (`GPM_IDX_PIN2_CFG << 2)
`define GPM_ADDR_IO_PORT (`GPM_IDX_IO_PORT << 2)
`define GPM_ADDR_IRQ_STAT 8'h40
`define GPM_ADDR_IRQ_MASK 8'h44
// Pin function configuration fields
`define GPM_DRV_HI 7
`define GPM_DRV_LO 6
`define GPM_PUP_BIT 5
`define GPM_FSEL_HI 4
`define GPM_FSEL_LO 0
// Port register fields
`define GPM_EXT_HI 6
`define GPM_EXT_LO 4
`define GPM_ITSDO_BIT 3
`define GPM_DIO_HI 2
`define GPM_DIO_LO 0
// Reset values
`define GPM_PIN2_CFG_RST 8'h00
`define GPM_IO_PORT_RST 8'h00
`define GPM_IRQ_MASK_RST 3'h0
`endif

// ===== src/gpm_pkg.sv
/*
 Types for the pin function mux: the pin function codes.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package gpm_pkg;
   typedef enum logic [4:0] {
      GPM_F_POR_N = 5'h00,
      GPM_F_WUT = 5'h01,
      GPM_F_LOWBAT = 5'h02,
      GPM_F_DIN = 5'h03,
      GPM_F_EXT_FALL = 5'h04,
      GPM_F_EXT_RISE = 5'h05,
      GPM_F_EXT_ANY = 5'h06,
      GPM_F_ADC = 5'h07,
      GPM_F_DOUT = 5'h0A,
      GPM_F_TXCLK = 5'h0F,
      GPM_F_TXDATA = 5'h10,
      GPM_F_RETX = 5'h11,
      GPM_F_TXSTATE = 5'h12,
      GPM_F_AFULL = 5'h13,
      GPM_F_VDD = 5'h1D
   } gpm_func_e;
endpackage

// ===== src/gpm_pin_mux.sv
/*
 Pin function mux and port control for three general-purpose pins, with an
 Avalon-MM slave for the third pin's configuration, the port register and
 an interrupt status/mask pair.
 Assumes all inputs synchronous to clk_sys_in; the first two pins' function
 codes come from configuration logic outside this block.
*/
`timescale 1ns/1ps
`include "gpm_params.svh"

// Functional notes
// - Bits 7:6 of pin 2 config set that pin's drive strength.
// - Pull-up bit connects pull-up only when pin 2 is a digital input.
// - Five-bit function select in bits 4:0; code 00000 drives inverted reset.
// - Code 00001 drives high once the wake-up timer expired.
// - Code 00010 drives high while battery is below threshold.
// - Code 00011 is direct input; 01010 is direct output set by software.
// - Codes 00100, 00101, 00110 interrupt on falling, rising, any edge.
// - Code 00111 routes pin to converter and disables digital use.
// - Code 01111 outputs transmit data clock; 10000 takes transmit data.
// - Code 10010 outputs transmit state; 10011 outputs buffer almost full.
// - Port bits 6:4 show external interrupt status of pins 2, 1, 0.
// - With bit 3 set and select high, interrupt request drives serial out.
// - Port bit 2 drives pin 2 as direct output, reads it as input.
// - Port bit 1 drives pin 1 as direct output, reads it as input.
// - Port bit 0 drives pin 0 as direct output, reads it as input.
module gpm_pin_mux
   import gpm_pkg::*;
#(
   parameter int NUM_PINS = 3
)
(
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   // Avalon-MM slave
   input wire logic [7:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // Function codes of the first two pins
   input wire logic [4:0] pin0_function_select_in,
   input wire logic [4:0] pin1_function_select_in,
   // Internal sources
   input wire logic por_in,
   input wire logic wakeup_timer_expired_in,
   input wire logic low_battery_in,
   input wire logic tx_data_clk_in,
   input wire logic tx_state_in,
   input wire logic tx_fifo_almost_full_in,
   input wire logic interrupt_request_n_in,
   // Serial port
   input wire logic serial_select_n_in,
   input wire logic spi_sdo_data_in,
   output logic sdo_out,
   output logic sdo_oe_n_out,
   // Pins
   input wire logic [NUM_PINS-1:0] pin_in,
   output logic [NUM_PINS-1:0] pin_out,
   output logic [NUM_PINS-1:0] pin_oe_n_out,
   output logic [1:0] pin_drive_strength_out,
   output logic pullup_enable_out,
   output logic [NUM_PINS-1:0] adc_input_sel_out,
   // Routed inputs
   output logic tx_data_out,
   output logic retx_request_out,
   // Interrupt
   output logic irq_out
);

   logic [7:0] pin2_cfg_q;
   logic itsdo_q;
   logic [NUM_PINS-1:0] dio_q;
   logic [NUM_PINS-1:0] prev_q;
   logic [NUM_PINS-1:0] ext_st_q;
   logic [NUM_PINS-1:0] irq_stat_q;
   logic [NUM_PINS-1:0] irq_mask_q;
   logic [4:0] fsel [NUM_PINS];
   logic [NUM_PINS-1:0] drv_d;
   logic [NUM_PINS-1:0] oe_n_d;
   logic [NUM_PINS-1:0] ext_ev;
   logic [NUM_PINS-1:0] is_din;
   logic [NUM_PINS-1:0] is_txd;
   logic [NUM_PINS-1:0] is_retx;
   logic [NUM_PINS-1:0] is_adc;
   logic [NUM_PINS-1:0] is_dig_in;
   logic [NUM_PINS-1:0] dio_rd;
   logic req;
   logic acc;
   logic acc_wr;
   logic acc_rd;
   logic [7:0] rd_d;
   localparam logic [7:0] PORT_RST = `GPM_IO_PORT_RST;

   assign fsel[0] = pin0_function_select_in;
   assign fsel[1] = pin1_function_select_in;
   assign fsel[2] = pin2_cfg_q[`GPM_FSEL_HI:`GPM_FSEL_LO];

   // Bus handshake: one wait cycle, access completes when waitrequest is low
   assign req = avs_read_in | avs_write_in;
   assign acc = req & ~avs_waitrequest_out;
   assign acc_wr = acc & avs_write_in & avs_byteenable_in[0];
   assign acc_rd = acc & avs_read_in;

   always_ff @(posedge clk_sys_in or negedge resetn_in)
   begin
      if (!resetn_in)
         avs_waitrequest_out <= 1'b1;
      else if (req && avs_waitrequest_out)
         avs_waitrequest_out <= 1'b0;
      else
         avs_waitrequest_out <= 1'b1;
   end

   // Per-pin function decode and edge detection
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi++)
      begin : g_pin
         always_comb
         begin
            drv_d[gi] = 1'b0;
            oe_n_d[gi] = 1'b0;
            case (fsel[gi])
               GPM_F_POR_N: drv_d[gi] = ~por_in;
               GPM_F_WUT: drv_d[gi] = wakeup_timer_expired_in;
               GPM_F_LOWBAT: drv_d[gi] = low_battery_in;
               GPM_F_DOUT: drv_d[gi] = dio_q[gi];
               GPM_F_TXCLK: drv_d[gi] = tx_data_clk_in;
               GPM_F_TXSTATE: drv_d[gi] = tx_state_in;
               GPM_F_AFULL: drv_d[gi] = tx_fifo_almost_full_in;
               GPM_F_VDD: drv_d[gi] = 1'b1;
               GPM_F_DIN, GPM_F_EXT_FALL, GPM_F_EXT_RISE, GPM_F_EXT_ANY,
               GPM_F_ADC, GPM_F_TXDATA, GPM_F_RETX: oe_n_d[gi] = 1'b1;
               default: drv_d[gi] = 1'b0;
            endcase
         end

         assign is_din[gi] = (fsel[gi] == GPM_F_DIN);
         assign is_txd[gi] = (fsel[gi] == GPM_F_TXDATA);
         assign is_retx[gi] = (fsel[gi] == GPM_F_RETX);
         assign is_adc[gi] = (fsel[gi] == GPM_F_ADC);
         assign is_dig_in[gi] = oe_n_d[gi] & ~is_adc[gi];
         assign dio_rd[gi] = is_din[gi] ? prev_q[gi] : dio_q[gi];
         always_comb
         begin
            case (fsel[gi])
               GPM_F_EXT_FALL: ext_ev[gi] = prev_q[gi] & ~pin_in[gi];
               GPM_F_EXT_RISE: ext_ev[gi] = ~prev_q[gi] & pin_in[gi];
               GPM_F_EXT_ANY: ext_ev[gi] = prev_q[gi] ^ pin_in[gi];
               default: ext_ev[gi] = 1'b0;
            endcase
         end
      end
   endgenerate

   // Pin drivers
   always_ff @(posedge clk_sys_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         pin_out <= '0;
         pin_oe_n_out <= '1;
         adc_input_sel_out <= '0;
         prev_q <= '0;
      end
      else
      begin
         pin_out <= drv_d;
         pin_oe_n_out <= oe_n_d;
         adc_input_sel_out <= is_adc;
         prev_q <= pin_in;
      end
   end

   // Pin 2 electrical settings
   always_ff @(posedge clk_sys_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         pin_drive_strength_out <= 2'h0;
         pullup_enable_out <= 1'b0;
      end
      else
      begin
         pin_drive_strength_out <= pin2_cfg_q[`GPM_DRV_HI:`GPM_DRV_LO];
         pullup_enable_out <= pin2_cfg_q[`GPM_PUP_BIT] & is_dig_in[2];
      end
   end

   // Routed input functions
   always_ff @(posedge clk_sys_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         tx_data_out <= 1'b0;
         retx_request_out <= 1'b0;
      end
      else
      begin
         tx_data_out <= |(is_txd & pin_in);
         retx_request_out <= |(is_retx & pin_in);
      end
   end

   // Serial output: interrupt request shown while select is idle
   always_ff @(posedge clk_sys_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         sdo_out <= 1'b0;
         sdo_oe_n_out <= 1'b1;
      end
      else if (!serial_select_n_in)
      begin
         sdo_out <= spi_sdo_data_in;
         sdo_oe_n_out <= 1'b0;
      end
      else
      begin
         sdo_out <= itsdo_q & interrupt_request_n_in;
         sdo_oe_n_out <= ~itsdo_q;
      end
   end

   // Configuration writes
   always_ff @(posedge clk_sys_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         pin2_cfg_q <= `GPM_PIN2_CFG_RST;
         itsdo_q <= PORT_RST[`GPM_ITSDO_BIT];
         dio_q <= PORT_RST[`GPM_DIO_HI:`GPM_DIO_LO];
         irq_mask_q <= `GPM_IRQ_MASK_RST;
      end
      else if (acc_wr)
      begin
         case (avs_address_in)
            `GPM_ADDR_PIN2_CFG: pin2_cfg_q <= avs_writedata_in[7:0];
            `GPM_ADDR_IO_PORT:
            begin
               itsdo_q <= avs_writedata_in[`GPM_ITSDO_BIT];
               dio_q <= avs_writedata_in[`GPM_DIO_HI:`GPM_DIO_LO];
            end
            `GPM_ADDR_IRQ_MASK: irq_mask_q <= avs_writedata_in[NUM_PINS-1:0];
            default: ;
         endcase
      end
   end

   // Sticky status; reads clear only the bits they returned, new events win
   always_ff @(posedge clk_sys_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         ext_st_q <= '0;
         irq_stat_q <= '0;
      end
      else
      begin
         if (acc_rd && avs_address_in == `GPM_ADDR_IO_PORT)
            ext_st_q <= (ext_st_q & ~avs_readdata_out[`GPM_EXT_HI:`GPM_EXT_LO]) | ext_ev;
         else
            ext_st_q <= ext_st_q | ext_ev;
         if (acc_rd && avs_address_in == `GPM_ADDR_IRQ_STAT)
            irq_stat_q <= (irq_stat_q & ~avs_readdata_out[NUM_PINS-1:0]) | ext_ev;
         else
            irq_stat_q <= irq_stat_q | ext_ev;
      end
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in)
   begin
      if (!resetn_in)
         irq_out <= 1'b0;
      else
         irq_out <= |(irq_stat_q & irq_mask_q);
   end

   // Read data is captured in the wait cycle and held through completion
   always_comb
   begin
      rd_d = 8'h00;
      case (avs_address_in)
         `GPM_ADDR_PIN2_CFG: rd_d = pin2_cfg_q;
         `GPM_ADDR_IO_PORT: rd_d = {1'b0, ext_st_q, itsdo_q, dio_rd};
         `GPM_ADDR_IRQ_STAT: rd_d = {5'h00, irq_stat_q};
         `GPM_ADDR_IRQ_MASK: rd_d = {5'h00, irq_mask_q};
         default: rd_d = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in)
   begin
      if (!resetn_in)
         avs_readdata_out <= 32'h0000_0000;
      else if (avs_read_in && avs_waitrequest_out)
         avs_readdata_out <= {24'h00_0000, rd_d};
   end

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!resetn_in);

   property p_drive;
      ##1 pin_drive_strength_out == $past(pin2_cfg_q[7:6]);
   endproperty
   a_drive: assert property (p_drive) else $error("drive strength mismatch");

   property p_pullup;
      (pin2_cfg_q[5] && fsel[2] == GPM_F_DOUT) |=> !pullup_enable_out;
   endproperty
   a_pullup: assert property (p_pullup) else $error("pull-up on output pin");

   property p_por;
      (fsel[2] == GPM_F_POR_N) |=> (pin_out[2] == !$past(por_in)) && !pin_oe_n_out[2];
   endproperty
   a_por: assert property (p_por) else $error("reset output wrong");

   property p_wut;
      (fsel[1] == GPM_F_WUT) |=> pin_out[1] == $past(wakeup_timer_expired_in);
   endproperty
   a_wut: assert property (p_wut) else $error("wake-up output wrong");

   property p_lowbat;
      (fsel[0] == GPM_F_LOWBAT && low_battery_in) |=> pin_out[0];
   endproperty
   a_lowbat: assert property (p_lowbat) else $error("low battery output wrong");

   property p_dout;
      (fsel[2] == GPM_F_DOUT) |=> pin_out[2] == $past(dio_q[2]) && !pin_oe_n_out[2];
   endproperty
   a_dout: assert property (p_dout) else $error("direct output wrong");

   sequence s_fall2;
      fsel[2] == GPM_F_EXT_FALL && prev_q[2] && !pin_in[2];
   endsequence
   property p_fall;
      s_fall2 |=> (ext_st_q[2] && irq_stat_q[2]) ##1 (irq_out || !$past(irq_mask_q[2]));
   endproperty
   a_fall: assert property (p_fall) else $error("falling edge not latched");

   property p_sdo;
      (serial_select_n_in && itsdo_q) |=> !sdo_oe_n_out
         && sdo_out == $past(interrupt_request_n_in);
   endproperty
   a_sdo: assert property (p_sdo) else $error("interrupt not on serial out");

   property p_vdd;
      (fsel[2] == GPM_F_VDD) [*2] |=> pin_out[2];
   endproperty
   a_vdd: assert property (p_vdd) else $error("constant high code wrong");

endmodule // gpm_pin_mux

// ===== tb/gpm_pin_partner.sv
/*
 External circuitry on the three pins: drives a pin only while the mux
 releases it. Assumes the bench sets the drive enables and levels.
*/
`timescale 1ns/1ps
module gpm_pin_partner
(
   // Clock
   input wire logic clk_sys_in,
   // From the mux
   input wire logic [2:0] pin_out_in,
   input wire logic [2:0] pin_oe_n_in,
   input wire logic pullup_enable_in,
   // From the bench
   input wire logic [2:0] ext_en_in,
   input wire logic [2:0] ext_val_in,
   // Resolved pin levels
   output logic [2:0] level_out
);
   logic toggle_q = 1'b0;
   always @(posedge clk_sys_in)
   begin
      toggle_q <= ~toggle_q;
   end
   // An undriven pin without pull-up wanders
   always_comb
   begin
      for (int i = 0; i < 3; i++)
      begin
         if (pin_oe_n_in[i] === 1'b0)
            level_out[i] = pin_out_in[i];
         else if (ext_en_in[i])
            level_out[i] = ext_val_in[i];
         else if (i == 2 && pullup_enable_in)
            level_out[i] = 1'b1;
         else
            level_out[i] = toggle_q;
      end
   end
endmodule // gpm_pin_partner

// ===== tb/gpm_pin_mux_test.sv
/*
 Self-checking bench of the pin function mux over its Avalon-MM slave.
 Assumes the partner model closes the pin loop.
*/
`timescale 1ns/1ps
module gpm_pin_mux_test
   import gpm_pkg::*;
;
   logic clk_sys_in = 1'b0;
   logic resetn_in = 1'b0;
   logic [7:0] avs_address_in = 8'h00;
   logic avs_read_in = 1'b0;
   logic avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = 32'h0;
   logic [3:0] avs_byteenable_in = 4'hF;
   logic [31:0] avs_readdata_out;
   logic avs_waitrequest_out;
   logic [4:0] pin0_sel = 5'h0A;
   logic [4:0] pin1_sel = 5'h03;
   logic [7:0] src = 8'h00;
   logic serial_select_n_in = 1'b1;
   logic sdo_out, sdo_oe_n_out, pullup_enable_out, tx_data_out, retx_request_out, irq_out;
   logic [2:0] pin_in, pin_out_out, pin_oe_n_out, adc_input_sel_out;
   logic [2:0] ext_en = 3'b110;
   logic [2:0] ext_val = 3'b000;
   logic [1:0] pin_drive_strength_out;
   logic [31:0] rng = 32'h00005FDE;
   logic [31:0] exp_q[$];
   logic e;
   int n_mismatch = 0;
   int n_compared = 0;
   gpm_func_e fc[9] = '{GPM_F_POR_N, GPM_F_WUT, GPM_F_LOWBAT, GPM_F_DOUT, GPM_F_TXCLK,
      GPM_F_TXSTATE, GPM_F_AFULL, GPM_F_VDD, gpm_func_e'(5'h15)};
   gpm_func_e ic[3] = '{GPM_F_EXT_FALL, GPM_F_EXT_RISE, GPM_F_EXT_ANY};
   always #2.5 clk_sys_in = ~clk_sys_in;
   gpm_pin_mux uut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out), .pin0_function_select_in(pin0_sel),
      .pin1_function_select_in(pin1_sel), .por_in(src[7]),
      .wakeup_timer_expired_in(src[6]), .low_battery_in(src[5]), .tx_data_clk_in(src[4]),
      .tx_state_in(src[3]), .tx_fifo_almost_full_in(src[2]),
      .interrupt_request_n_in(src[1]), .serial_select_n_in(serial_select_n_in),
      .spi_sdo_data_in(src[0]), .sdo_out(sdo_out), .sdo_oe_n_out(sdo_oe_n_out),
      .pin_in(pin_in), .pin_out(pin_out_out), .pin_oe_n_out(pin_oe_n_out),
      .pin_drive_strength_out(pin_drive_strength_out),
      .pullup_enable_out(pullup_enable_out), .adc_input_sel_out(adc_input_sel_out),
      .tx_data_out(tx_data_out), .retx_request_out(retx_request_out), .irq_out(irq_out));
   gpm_pin_partner partner (.clk_sys_in(clk_sys_in), .pin_out_in(pin_out_out),
      .pin_oe_n_in(pin_oe_n_out), .pullup_enable_in(pullup_enable_out),
      .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(pin_in));
   task automatic complete_run;
      $display("mismatches %0d compared %0d", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] expv);
      n_compared++;
      if (seen !== expv)
      begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
      end
   endtask
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s;
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int k;
      @(posedge clk_sys_in);
      avs_address_in <= a;
      avs_writedata_in <= {24'h000000, d};
      avs_write_in <= wr;
      avs_read_in <= ~wr;
      for (k = 0; k < 20; k++)
      begin
         @(posedge clk_sys_in);
         if (avs_waitrequest_out === 1'b0)
            break;
      end
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
      if (k == 20)
      begin
         n_mismatch++;
         complete_run();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] ev);
      exp_q.push_back({24'h000000, ev});
      bus(1'b0, a, 8'h00);
   endtask
   task automatic settle;
      repeat (3) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
   endtask
   // Read data are compared when the slave answers
   always @(posedge clk_sys_in)
   begin
      if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0)
      begin
         if (exp_q.size() == 0)
            n_mismatch++;
         else
            check(avs_readdata_out, exp_q.pop_front());
      end
   end
   initial
   begin
      repeat (10) @(posedge clk_sys_in);
      resetn_in <= 1'b1;
      settle();
      check(sdo_oe_n_out, 1'b1);
      rd(8'h30, 8'h00);
      rd(8'h38, 8'h00);
      rd(8'h3C, 8'h00);
      foreach (fc[i])
      begin
         bus(1'b1, 8'h30, {3'b000, fc[i]});
         rng = xorshift(rng);
         src <= rng[7:0];
         pin0_sel <= fc[i];
         pin1_sel <= fc[i];
         settle();
         case (fc[i])
            GPM_F_POR_N: e = ~src[7];
            GPM_F_WUT: e = src[6];
            GPM_F_LOWBAT: e = src[5];
            GPM_F_TXCLK: e = src[4];
            GPM_F_TXSTATE: e = src[3];
            GPM_F_AFULL: e = src[2];
            GPM_F_VDD: e = 1'b1;
            default: e = 1'b0;
         endcase
         check(pin_out_out, {3{e}});
         check(pin_oe_n_out, 3'b000);
      end
      @(posedge clk_sys_in);
      pin0_sel <= 5'h0A;
      pin1_sel <= 5'h03;
      foreach (ic[i])
      begin
         e = (ic[i] == GPM_F_EXT_FALL);
         bus(1'b1, 8'h44, 8'h07);
         bus(1'b1, 8'h30, 8'h03);
         ext_val[2] <= e;
         bus(1'b1, 8'h30, {3'b000, ic[i]});
         settle();
         @(posedge clk_sys_in);
         ext_val[2] <= ~e;
         settle();
         check(irq_out, 1'b1);
         rd(8'h38, 8'h40);
         rd(8'h40, 8'h04);
         settle();
         check(irq_out, 1'b0);
         bus(1'b1, 8'h44, 8'h00);
         ext_val[2] <= e;
         settle();
         check(irq_out, 1'b0);
         rd(8'h38, (ic[i] == GPM_F_EXT_ANY) ? 8'h40 : 8'h00);
         rd(8'h40, (ic[i] == GPM_F_EXT_ANY) ? 8'h04 : 8'h00);
      end
      bus(1'b1, 8'h30, 8'h23);
      ext_en <= 3'b010;
      settle();
      check(pullup_enable_out, 1'b1);
      rd(8'h38, 8'h04);
      bus(1'b1, 8'h30, 8'hCA);
      bus(1'b1, 8'h38, 8'h05);
      ext_val <= 3'b010;
      settle();
      check({pin_drive_strength_out, pullup_enable_out}, 3'b110);
      check({pin_oe_n_out[2], pin_out_out[2], pin_out_out[0]}, 3'b011);
      rd(8'h38, 8'h07);
      avs_byteenable_in <= 4'h0;
      bus(1'b1, 8'h38, 8'h00);
      avs_byteenable_in <= 4'hF;
      rd(8'h38, 8'h07);
      bus(1'b1, 8'h30, 8'h27);
      settle();
      check({adc_input_sel_out[2], pin_oe_n_out[2], pullup_enable_out}, 3'b110);
      bus(1'b1, 8'h30, 8'h10);
      ext_en <= 3'b110;
      ext_val <= 3'b100;
      settle();
      check(tx_data_out, 1'b1);
      bus(1'b1, 8'h30, 8'h11);
      settle();
      check(retx_request_out, 1'b1);
      bus(1'b1, 8'h38, 8'h08);
      for (int v = 0; v < 2; v++)
      begin
         @(posedge clk_sys_in);
         src <= {6'h00, v[0], ~v[0]};
         serial_select_n_in <= v[0];
         settle();
         check({sdo_oe_n_out, sdo_out}, 2'b01);
      end
      if (exp_q.size() != 0)
         n_mismatch++;
      complete_run();
   end
endmodule // gpm_pin_mux_test
